//--- cdcrs_top.sv
// How it works
// - combined flag low when enabled channels done
// - both enabled: low only after both finish
// - combined flag high on read or next result
// - capacitive only: combined follows capacitive flag
// - aux flag low on fresh unread result
// - capacitive flag low on fresh unread result
// - status bits 7..3 always read zero
// - ready pin equals combined flag
// - capacitive result at pointers 1..3, MSB first
// - capacitive register frozen from the cycle after its first byte is fetched
// - stop ends read, updates resume after
// - capacitive code is offset binary
// - aux result at pointers 4..6
// - aux register frozen from the cycle after its first byte is fetched
// - voltage code is offset binary
// - temperature code divided 2048 minus 4096
// - reset: status 0x07, results zero
// - pointer increments per byte, twice for a refused last byte, until stop
// - capacitive results only when channel enabled
`timescale 1ns/100ps
`include "cdcrs_params.svh"
module cdcrs_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // 2-wire serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // converter results
  input wire logic capacitive_channel_on_in,
  input wire logic voltage_temperature_channel_on_in,
  input wire logic cap_valid_in,
  input wire logic [23:0] cap_result_in,
  input wire logic aux_valid_in,
  input wire logic [23:0] aux_result_in,
  // ready pin
  output logic rdy_n_out
);
  cdcrs_chan_if cap_ch ();
  cdcrs_chan_if aux_ch ();

  logic [1:0] pins;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  cdcrs_pkg::cdcrs_i2c_state_t state;
  logic [3:0] bit_cnt;
  cdcrs_pkg::cdcrs_byte_t shift_rx;
  cdcrs_pkg::cdcrs_byte_t shift_tx;
  cdcrs_pkg::cdcrs_byte_t ptr;
  cdcrs_pkg::cdcrs_byte_t read_byte;
  logic rw_read;
  logic master_ack;
  logic load_tx;
  logic rdy_n;
  logic rnd_cap;
  logic rnd_aux;
  logic next_rnd_cap;
  logic next_rnd_aux;
  logic any_load;
  logic round_done;
  logic cap_en;
  logic aux_en;
  logic next_rdy_n;
  cdcrs_pkg::cdcrs_byte_t status_byte;

  // ==========================================================
  // pin synchronisers and bus events
  cdcrs_sync u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .async_in({sda_in, scl_in}),
    .sync_out(pins)
  );

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pins[`CDCRS_PIN_SCL];
      sda_q <= pins[`CDCRS_PIN_SDA];
    end
  end

  assign scl_rise = pins[`CDCRS_PIN_SCL] & ~scl_q;
  assign scl_fall = ~pins[`CDCRS_PIN_SCL] & scl_q;
  assign bus_start = scl_q & pins[`CDCRS_PIN_SCL] & sda_q & ~pins[`CDCRS_PIN_SDA];
  assign bus_stop = scl_q & pins[`CDCRS_PIN_SCL] & ~sda_q & pins[`CDCRS_PIN_SDA];

  // ==========================================================
  // result registers
  assign cap_en = capacitive_channel_on_in;
  assign aux_en = voltage_temperature_channel_on_in;
  assign cap_ch.valid = cap_valid_in & cap_en;
  assign cap_ch.data = cap_result_in;
  assign cap_ch.bus_stop = bus_stop;
  assign aux_ch.valid = aux_valid_in & aux_en;
  assign aux_ch.data = aux_result_in;
  assign aux_ch.bus_stop = bus_stop;

  // a data byte fetched by the bus freezes its register until stop
  assign load_tx = (state == cdcrs_pkg::CDCRS_ADDR_ACK && scl_fall && rw_read)
    || (state == cdcrs_pkg::CDCRS_RACK && scl_fall && master_ack);
  assign cap_ch.hold_set = load_tx && ptr >= `CDCRS_ADDR_CAP_H && ptr <= `CDCRS_ADDR_CAP_L;
  assign aux_ch.hold_set = load_tx && ptr >= `CDCRS_ADDR_AUX_H && ptr <= `CDCRS_ADDR_AUX_L;

  cdcrs_result_reg u_cap (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ch(cap_ch.reg_side)
  );

  cdcrs_result_reg u_aux (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .ch(aux_ch.reg_side)
  );

  // ==========================================================
  // combined flag
  // a round collects one fresh result per enabled channel
  assign next_rnd_cap = rnd_cap | cap_ch.loaded;
  assign next_rnd_aux = rnd_aux | aux_ch.loaded;
  assign any_load = cap_ch.loaded | aux_ch.loaded;
  assign round_done = any_load && (cap_en || aux_en)
    && (!cap_en || next_rnd_cap) && (!aux_en || next_rnd_aux);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      rnd_cap <= 1'b0;
      rnd_aux <= 1'b0;
    end else if (round_done) begin
      rnd_cap <= 1'b0;
      rnd_aux <= 1'b0;
    end else begin
      rnd_cap <= next_rnd_cap;
      rnd_aux <= next_rnd_aux;
    end
  end

  // flag and pin share one next value so they never differ
  always_comb begin
    next_rdy_n = rdy_n;
    if (round_done) begin
      next_rdy_n = `CDCRS_FLAG_DONE;
    end else if (any_load || (cap_ch.read_done && cap_en) || (aux_ch.read_done && aux_en)) begin
      next_rdy_n = `CDCRS_FLAG_IDLE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      rdy_n <= `CDCRS_FLAG_IDLE;
      rdy_n_out <= `CDCRS_FLAG_IDLE;
    end else begin
      rdy_n <= next_rdy_n;
      rdy_n_out <= next_rdy_n;
    end
  end

  // ==========================================================
  // read multiplexer
  // unused upper status bits are tied here, no state can leak through them
  assign status_byte = {`CDCRS_UNUSED_BITS, rdy_n, aux_ch.done_n, cap_ch.done_n};

  always_comb begin
    case (ptr)
      `CDCRS_ADDR_STATUS: read_byte = status_byte;
      `CDCRS_ADDR_CAP_H: read_byte = cap_ch.value[`CDCRS_HI_MSB:`CDCRS_HI_LSB];
      `CDCRS_ADDR_CAP_M: read_byte = cap_ch.value[`CDCRS_MID_MSB:`CDCRS_MID_LSB];
      `CDCRS_ADDR_CAP_L: read_byte = cap_ch.value[`CDCRS_LO_MSB:`CDCRS_LO_LSB];
      `CDCRS_ADDR_AUX_H: read_byte = aux_ch.value[`CDCRS_HI_MSB:`CDCRS_HI_LSB];
      `CDCRS_ADDR_AUX_M: read_byte = aux_ch.value[`CDCRS_MID_MSB:`CDCRS_MID_LSB];
      `CDCRS_ADDR_AUX_L: read_byte = aux_ch.value[`CDCRS_LO_MSB:`CDCRS_LO_LSB];
      default: read_byte = `CDCRS_BYTE_ZERO;
    endcase
  end

  // ==========================================================
  // serial slave state machine
  // limitation: scl must stay low for several ref clocks, fine for standard bus rates
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      state <= cdcrs_pkg::CDCRS_IDLE;
      bit_cnt <= `CDCRS_CNT_ZERO;
      shift_tx <= `CDCRS_BYTE_ZERO;
      rw_read <= 1'b0;
    end else if (bus_stop) begin
      state <= cdcrs_pkg::CDCRS_IDLE;
      bit_cnt <= `CDCRS_CNT_ZERO;
      rw_read <= 1'b0;
    end else if (bus_start) begin
      state <= cdcrs_pkg::CDCRS_ADDR;
      bit_cnt <= `CDCRS_CNT_ZERO;
    end else begin
      if (scl_rise) begin
        bit_cnt <= bit_cnt + `CDCRS_CNT_STEP;
      end
      if (scl_fall) begin
        case (state)
          cdcrs_pkg::CDCRS_ADDR: begin
            if (bit_cnt == `CDCRS_BITS_PER_BYTE) begin
              if (shift_rx[`CDCRS_SLAVE_MSB:`CDCRS_SLAVE_LSB] == `CDCRS_SLAVE_ADDR) begin
                state <= cdcrs_pkg::CDCRS_ADDR_ACK;
                rw_read <= shift_rx[`CDCRS_RW_BIT];
              end else begin
                state <= cdcrs_pkg::CDCRS_IDLE;
              end
            end
          end
          cdcrs_pkg::CDCRS_ADDR_ACK: begin
            bit_cnt <= `CDCRS_CNT_ZERO;
            if (rw_read) begin
              state <= cdcrs_pkg::CDCRS_RDATA;
              shift_tx <= read_byte;
            end else begin
              state <= cdcrs_pkg::CDCRS_PTR;
            end
          end
          cdcrs_pkg::CDCRS_PTR: begin
            if (bit_cnt == `CDCRS_BITS_PER_BYTE) begin
              state <= cdcrs_pkg::CDCRS_PTR_ACK;
            end
          end
          cdcrs_pkg::CDCRS_PTR_ACK: begin
            bit_cnt <= `CDCRS_CNT_ZERO;
            state <= cdcrs_pkg::CDCRS_WDATA;
          end
          cdcrs_pkg::CDCRS_WDATA: begin
            if (bit_cnt == `CDCRS_BITS_PER_BYTE) begin
              state <= cdcrs_pkg::CDCRS_WDATA_ACK;
            end
          end
          cdcrs_pkg::CDCRS_WDATA_ACK: begin
            bit_cnt <= `CDCRS_CNT_ZERO;
            state <= cdcrs_pkg::CDCRS_WDATA;
          end
          cdcrs_pkg::CDCRS_RDATA: begin
            if (bit_cnt == `CDCRS_BITS_PER_BYTE) begin
              state <= cdcrs_pkg::CDCRS_RACK;
            end else begin
              shift_tx <= {shift_tx[`CDCRS_BYTE_MSB-1:0], 1'b0};
            end
          end
          cdcrs_pkg::CDCRS_RACK: begin
            bit_cnt <= `CDCRS_CNT_ZERO;
            if (master_ack) begin
              state <= cdcrs_pkg::CDCRS_RDATA;
              shift_tx <= read_byte;
            end else begin
              state <= cdcrs_pkg::CDCRS_IDLE;
            end
          end
          default: begin
            state <= cdcrs_pkg::CDCRS_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // receive shifter; start and stop never coincide with an scl rise
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      shift_rx <= `CDCRS_BYTE_ZERO;
    end else if (scl_rise) begin
      shift_rx <= {shift_rx[`CDCRS_BYTE_MSB-1:0], pins[`CDCRS_PIN_SDA]};
    end
  end

  // master acknowledge, sampled on the ninth bit of a read byte
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      master_ack <= 1'b0;
    end else if (scl_rise && state == cdcrs_pkg::CDCRS_RACK) begin
      master_ack <= ~pins[`CDCRS_PIN_SDA];
    end
  end

  // ==========================================================
  // address pointer
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ptr <= `CDCRS_BYTE_ZERO;
    end else if (scl_fall && !bus_stop && !bus_start) begin
      if (state == cdcrs_pkg::CDCRS_PTR && bit_cnt == `CDCRS_BITS_PER_BYTE) begin
        ptr <= shift_rx;
      end else if (load_tx) begin
        ptr <= ptr + `CDCRS_PTR_STEP;
      end else if (state == cdcrs_pkg::CDCRS_RACK && !master_ack) begin
        // a refused last byte was still transferred
        ptr <= ptr + `CDCRS_PTR_STEP;
      end else if (state == cdcrs_pkg::CDCRS_WDATA && bit_cnt == `CDCRS_BITS_PER_BYTE) begin
        // written bytes are dropped, the registers here are read only
        ptr <= ptr + `CDCRS_PTR_STEP;
      end
    end
  end

  // ==========================================================
  // open-drain data pin; only a low is ever driven
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (bus_stop || bus_start) begin
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (scl_fall) begin
      sda_out <= 1'b0;
      case (state)
        cdcrs_pkg::CDCRS_ADDR: begin
          sda_oe_out <= bit_cnt == `CDCRS_BITS_PER_BYTE
            && shift_rx[`CDCRS_SLAVE_MSB:`CDCRS_SLAVE_LSB] == `CDCRS_SLAVE_ADDR;
        end
        cdcrs_pkg::CDCRS_PTR, cdcrs_pkg::CDCRS_WDATA: begin
          sda_oe_out <= bit_cnt == `CDCRS_BITS_PER_BYTE;
        end
        cdcrs_pkg::CDCRS_ADDR_ACK: begin
          sda_oe_out <= rw_read && !read_byte[`CDCRS_BYTE_MSB];
        end
        cdcrs_pkg::CDCRS_RDATA: begin
          sda_oe_out <= bit_cnt != `CDCRS_BITS_PER_BYTE && !shift_tx[`CDCRS_BYTE_MSB-1];
        end
        cdcrs_pkg::CDCRS_RACK: begin
          sda_oe_out <= master_ack && !read_byte[`CDCRS_BYTE_MSB];
        end
        default: begin
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end
endmodule

//--- cdcrs_params.svh
`ifndef CDCRS_PARAMS_SVH
`define CDCRS_PARAMS_SVH

// ==========================================================
// register pointer addresses
`define CDCRS_ADDR_STATUS 8'h00
`define CDCRS_ADDR_CAP_H 8'h01
`define CDCRS_ADDR_CAP_M 8'h02
`define CDCRS_ADDR_CAP_L 8'h03
`define CDCRS_ADDR_AUX_H 8'h04
`define CDCRS_ADDR_AUX_M 8'h05
`define CDCRS_ADDR_AUX_L 8'h06

// ==========================================================
// field layouts
`define CDCRS_HI_MSB 23
`define CDCRS_HI_LSB 16
`define CDCRS_MID_MSB 15
`define CDCRS_MID_LSB 8
`define CDCRS_LO_MSB 7
`define CDCRS_LO_LSB 0
`define CDCRS_BYTE_MSB 7
`define CDCRS_SLAVE_MSB 7
`define CDCRS_SLAVE_LSB 1
`define CDCRS_RW_BIT 0

// ==========================================================
// reset values and constants
`define CDCRS_FLAG_IDLE 1'b1
`define CDCRS_FLAG_DONE 1'b0
`define CDCRS_RESULT_RESET 24'h000000
`define CDCRS_UNUSED_BITS 5'h00
`define CDCRS_BYTE_ZERO 8'h00
`define CDCRS_PTR_STEP 8'h01
`define CDCRS_SLAVE_ADDR 7'h48
`define CDCRS_BITS_PER_BYTE 4'h8
`define CDCRS_CNT_ZERO 4'h0
`define CDCRS_CNT_STEP 4'h1
`define CDCRS_SYNC_IDLE 2'h3
`define CDCRS_PIN_SCL 0
`define CDCRS_PIN_SDA 1

`endif

//--- cdcrs_pkg.sv
package cdcrs_pkg;
  // ==========================================================
  // shared types
  typedef logic [23:0] cdcrs_result_t;
  typedef logic [7:0] cdcrs_byte_t;
  typedef enum logic [3:0] {
    CDCRS_IDLE,
    CDCRS_ADDR,
    CDCRS_ADDR_ACK,
    CDCRS_PTR,
    CDCRS_PTR_ACK,
    CDCRS_WDATA,
    CDCRS_WDATA_ACK,
    CDCRS_RDATA,
    CDCRS_RACK
  } cdcrs_i2c_state_t;
endpackage

//--- cdcrs_chan_if.sv
`timescale 1ns/100ps
interface cdcrs_chan_if;
  // ==========================================================
  // one result channel between bus logic and its register
  logic valid;
  cdcrs_pkg::cdcrs_result_t data;
  logic hold_set;
  logic bus_stop;
  cdcrs_pkg::cdcrs_result_t value;
  logic done_n;
  logic loaded;
  logic read_done;
  modport reg_side (
    input valid, data, hold_set, bus_stop,
    output value, done_n, loaded, read_done
  );
  modport bus_side (
    output valid, data, hold_set, bus_stop,
    input value, done_n, loaded, read_done
  );
endinterface

//--- cdcrs_sync.sv
`timescale 1ns/100ps
`include "cdcrs_params.svh"
module cdcrs_sync (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // pins
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] stage1;
  localparam logic [1:0] sync_idle = `CDCRS_SYNC_IDLE;

  // ==========================================================
  // two flops per pin; only the second stage is read
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_bit
      always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
          stage1[i] <= sync_idle[i];
          sync_out[i] <= sync_idle[i];
        end else begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule

//--- cdcrs_result_reg.sv
`timescale 1ns/100ps
`include "cdcrs_params.svh"
module cdcrs_result_reg (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // channel
  cdcrs_chan_if.reg_side ch
);
  logic hold;

  // ==========================================================
  // load and discard
  assign ch.loaded = ch.valid & ~hold;
  assign ch.read_done = ch.bus_stop & hold;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ch.value <= `CDCRS_RESULT_RESET;
    end else if (ch.loaded) begin
      // code passes through unchanged, converter supplies the scaling
      ch.value <= ch.data;
    end
  end

  // ==========================================================
  // hold from first data byte read until stop
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      hold <= 1'b0;
    end else if (ch.bus_stop) begin
      hold <= 1'b0;
    end else if (ch.hold_set) begin
      hold <= 1'b1;
    end
  end

  // ==========================================================
  // per-channel flag; a load beats a read completion
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ch.done_n <= `CDCRS_FLAG_IDLE;
    end else if (ch.loaded) begin
      ch.done_n <= `CDCRS_FLAG_DONE;
    end else if (ch.read_done) begin
      ch.done_n <= `CDCRS_FLAG_IDLE;
    end
  end
endmodule

//--- cdcrs_top_sva.sv
`timescale 1ns/100ps
module cdcrs_top_sva (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // 2-wire serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // converter results
  input wire logic capacitive_channel_on_in,
  input wire logic voltage_temperature_channel_on_in,
  input wire logic cap_valid_in,
  input wire logic [23:0] cap_result_in,
  input wire logic aux_valid_in,
  input wire logic [23:0] aux_result_in,
  // ready pin
  input wire logic rdy_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // bus activity helper
  // quiet waits out the synchroniser delay after a stop before calling the bus idle
  logic prev_sda;
  logic busy;
  logic [3:0] quiet;
  logic idle;
  logic cap_on;
  logic aux_on;
  assign idle = (quiet == 4'hF) && !busy;
  assign cap_on = capacitive_channel_on_in;
  assign aux_on = voltage_temperature_channel_on_in;
  always_ff @(posedge ref_clk_in) begin
    prev_sda <= sda_in;
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      busy <= 1'h0;
    end else if (scl_in && prev_sda && !sda_in) begin
      busy <= 1'h1;
    end else if (scl_in && !prev_sda && sda_in) begin
      busy <= 1'h0;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      quiet <= 4'hF;
    end else if (busy) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  // ==========================================================
  // assertions
  a_reset_idle: assert property ($rose(rst_b_in) |-> rdy_n_out && !sda_oe_out)
    else $error("ready pin or data drive active after reset");
  a_cap_only_done: assert property (idle && cap_on && !aux_on && cap_valid_in |=> !rdy_n_out)
    else $error("ready pin did not follow capacitive result");
  a_aux_only_done: assert property (idle && aux_on && !cap_on && aux_valid_in |=> !rdy_n_out)
    else $error("ready pin did not fall on aux result");
  a_fall_has_cause: assert property ($fell(rdy_n_out) |-> $past(cap_valid_in) || $past(aux_valid_in))
    else $error("ready pin fell without a result");
  a_rise_has_cause: assert property ($rose(rdy_n_out) |-> $past(cap_valid_in) || $past(aux_valid_in) || !idle)
    else $error("ready pin rose without read or result");
  a_disabled_ignored: assert property (!cap_on && !aux_on |=> $stable(rdy_n_out))
    else $error("ready pin moved with channels disabled");
  a_ready_low_stays: assert property (idle && !rdy_n_out && !cap_valid_in && !aux_valid_in |=> !rdy_n_out)
    else $error("ready pin released without cause");
  a_no_drive_idle: assert property (idle |-> !sda_oe_out)
    else $error("data line driven on idle bus");
  c_ready_fell: cover property ($fell(rdy_n_out));
  c_both_done: cover property (cap_on && aux_on && $fell(rdy_n_out));
  c_data_driven: cover property ($rose(sda_oe_out));
endmodule

bind cdcrs_top cdcrs_top_sva chk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .capacitive_channel_on_in(capacitive_channel_on_in),
  .voltage_temperature_channel_on_in(voltage_temperature_channel_on_in), .cap_valid_in(cap_valid_in),
  .cap_result_in(cap_result_in), .aux_valid_in(aux_valid_in), .aux_result_in(aux_result_in), .rdy_n_out(rdy_n_out));

//--- cdcrs_host_model.sv
`timescale 1ns/100ps
`include "cdcrs_params.svh"
module cdcrs_host_model (
  // clock
  input wire logic clk_in,
  // bus pins
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // ==========================================================
  // bus master
  // scl low lasts 8 clocks, well above the slave's minimum
  logic ack_err;
  initial begin
    scl_out = 1'h1;
    sda_low_out = 1'h0;
    ack_err = 1'h0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic put_bit(input logic b, output logic r);
    sda_low_out = ~b;
    q(4);
    scl_out = 1'h1;
    q(4);
    r = sda_in;
    q(4);
    scl_out = 1'h0;
    q(4);
  endtask
  task automatic start_cond();
    sda_low_out = 1'h0;
    q(4);
    scl_out = 1'h1;
    q(8);
    sda_low_out = 1'h1;
    q(8);
    scl_out = 1'h0;
    q(4);
  endtask
  task automatic stop_cond();
    sda_low_out = 1'h1;
    q(4);
    scl_out = 1'h1;
    q(8);
    sda_low_out = 1'h0;
    q(20);
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], r);
      rx[i] = r;
    end
    put_bit(mack, ack);
  endtask
  task automatic read_regs(input logic [7:0] ptr, input int n, output logic [23:0] val);
    logic [7:0] rx;
    logic a;
    val = 24'h000000;
    start_cond();
    xfer({`CDCRS_SLAVE_ADDR, 1'h0}, 1'h1, rx, a);
    ack_err |= a;
    xfer(ptr, 1'h1, rx, a);
    ack_err |= a;
    start_cond();
    xfer({`CDCRS_SLAVE_ADDR, 1'h1}, 1'h1, rx, a);
    ack_err |= a;
    // whole register in one transfer, last byte not acknowledged
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, (i == n - 1), rx, a);
      val = {val[15:0], rx};
    end
    stop_cond();
  endtask
endmodule

//--- cdc_result_status_regs_bench.sv
`timescale 1ns/100ps
module cdc_result_status_regs_bench;
  logic ref_clk_in;
  logic rst_b_in;
  logic cap_on;
  logic aux_on;
  logic cap_valid;
  logic aux_valid;
  logic [23:0] cap_res;
  logic [23:0] aux_res;
  logic scl;
  logic host_low;
  logic sda_drv;
  logic sda_oe;
  logic rdy_n;
  wire sda_w;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // open-drain line with pull-up
  assign sda_w = (sda_oe ? sda_drv : 1'h1) & ~host_low;
  cdcrs_top dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .capacitive_channel_on_in(cap_on), .voltage_temperature_channel_on_in(aux_on),
    .cap_valid_in(cap_valid), .cap_result_in(cap_res), .aux_valid_in(aux_valid), .aux_result_in(aux_res),
    .rdy_n_out(rdy_n));
  cdcrs_host_model host (.clk_in(ref_clk_in), .sda_in(sda_w), .scl_out(scl), .sda_low_out(host_low));
  // ==========================================================
  // shared tasks
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic aux, input logic [23:0] v);
    @(posedge ref_clk_in);
    #1;
    if (aux) begin
      aux_valid = 1'h1;
      aux_res = v;
    end else begin
      cap_valid = 1'h1;
      cap_res = v;
    end
    @(posedge ref_clk_in);
    #1;
    cap_valid = 1'h0;
    aux_valid = 1'h0;
    cap_res = ~cap_res;
    aux_res = ~aux_res;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [23:0] v;
    check({23'h0, rdy_n}, 24'h000001);
    host.read_regs(8'h00, 1, v);
    check(v, 24'h000007);
    host.read_regs(8'h01, 3, v);
    check(v, 24'h000000);
    host.read_regs(8'h04, 3, v);
    check(v, 24'h000000);
  endtask
  task automatic t_cap_only();
    logic [23:0] v;
    logic [23:0] codes [3] = '{24'h000000, 24'h800000, 24'hFFFFFF};
    cap_on = 1'h1;
    aux_on = 1'h0;
    foreach (codes[i]) begin
      load(1'h0, codes[i]);
      check({23'h0, rdy_n}, 24'h000000);
      host.read_regs(8'h00, 1, v);
      check(v, 24'h000002);
      host.read_regs(8'h01, 3, v);
      check(v, codes[i]);
      check({23'h0, rdy_n}, 24'h000001);
      host.read_regs(8'h00, 1, v);
      check(v, 24'h000007);
    end
  endtask
  task automatic t_both();
    logic [23:0] v;
    cap_on = 1'h1;
    aux_on = 1'h1;
    load(1'h0, 24'h123456);
    check({23'h0, rdy_n}, 24'h000001);
    load(1'h1, 24'h80C800);
    check({23'h0, rdy_n}, 24'h000000);
    load(1'h0, 24'h654321);
    check({23'h0, rdy_n}, 24'h000001);
    // status then two cap bytes through the auto-incremented pointer
    host.read_regs(8'h00, 3, v);
    check(v, 24'h046543);
    host.read_regs(8'h04, 3, v);
    check(v, 24'h80C800);
    host.read_regs(8'h00, 1, v);
    check(v, 24'h000007);
  endtask
  task automatic t_hold(input logic aux);
    logic [23:0] v;
    logic [7:0] p;
    p = aux ? 8'h04 : 8'h01;
    cap_on = ~aux;
    aux_on = aux;
    load(aux, 24'hA5A5A5);
    // second result lands while the data bytes are being shifted out
    fork
      host.read_regs(p, 3, v);
      begin
        repeat (600) @(posedge ref_clk_in);
        load(aux, 24'h5A5A5A);
      end
    join
    check(v, 24'hA5A5A5);
    check({23'h0, rdy_n}, 24'h000001);
    // the result that landed during the read must have been dropped
    host.read_regs(p, 3, v);
    check(v, 24'hA5A5A5);
    load(aux, 24'h3C3C3C);
    host.read_regs(p, 3, v);
    check(v, 24'h3C3C3C);
  endtask
  task automatic t_off();
    logic [23:0] v;
    cap_on = 1'h0;
    aux_on = 1'h0;
    load(1'h0, 24'h111111);
    check({23'h0, rdy_n}, 24'h000001);
    host.read_regs(8'h01, 3, v);
    check(v, 24'h3C3C3C);
    check({23'h0, host.ack_err}, 24'h000000);
  endtask
  // ==========================================================
  // clock, timeout and main sequence
  initial begin
    ref_clk_in = 1'h0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    rst_b_in = 1'h0;
    cap_on = 1'h0;
    aux_on = 1'h0;
    cap_valid = 1'h0;
    aux_valid = 1'h0;
    cap_res = 24'h000000;
    aux_res = 24'h000000;
    repeat (4) @(posedge ref_clk_in);
    #1;
    rst_b_in = 1'h1;
    repeat (4) @(posedge ref_clk_in);
    #1;
    t_reset();
    t_cap_only();
    t_both();
    t_hold(1'h0);
    t_hold(1'h1);
    t_off();
    stop_test();
  end
endmodule
